/* File: lddpc_controller.sv */
// log dimming pwm controller: duty conversion, dimming pulse, channel faults, apb registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "lddpc_defines.svh"

// Summary of operation
// [R1] range low: internal dimming pulse period clamped to 100 Hz .. 2 kHz
// [R2] range high: internal dimming pulse period clamped to 1.5 kHz .. 20 kHz
// [R3] frequency select high: range input pulse gates channels directly, no conversion
// [R4] internal mode: averaged input duty quantised to one of sixteen log levels
// [R5] level steps per 6.25 percent input duty; output ratio ten to (N-1)/7 percent for levels 1..15, zero at level 0
// [R6] step up only when average exceeds current nominal by 4.16 percent
// [R7] step down only when average falls 4.16 percent below current nominal
// [R8] resulting 2 percent band between neighbour thresholds stops level toggling
// [R9] level decisions use a running average over many input pulses
// [R10] input may run 100 Hz .. 40 kHz; output period set only by register
// [R11] channel sense below open threshold switches that channel off alone
// [R12] channel sense above short threshold switches that channel off alone
// [R13] faulted channel stops driving its sense output, left high impedance
// [R14] enable is always driven by the controlling party, high runs, low disables
// [R15] feedback ground switch closed while enabled, open while disabled
// [R16] boost stage idle in the gaps between internal dimming pulses
// [R17] boost switches while dimming pulse high, stops while low
// [R18] channel fault latched; only reset clears it
// [R19] after four faulted channels no further faults are detected
// [R20] duty measured from high and total cycle counts per input period
// [R21] pulse from programmable period counter; high time is ratio times period
module lddpc_controller #(
  parameter int PER_W = 22,
  parameter int LF_MIN_PER = `LDDPC_CLK_HZ / `LDDPC_LF_MAX_HZ,
  parameter int LF_MAX_PER = `LDDPC_CLK_HZ / `LDDPC_LF_MIN_HZ,
  parameter int HF_MIN_PER = `LDDPC_CLK_HZ / `LDDPC_HF_MAX_HZ,
  parameter int HF_MAX_PER = `LDDPC_CLK_HZ / `LDDPC_HF_MIN_HZ,
  parameter int PER_RST = `LDDPC_CLK_HZ / `LDDPC_DIM_DEF_HZ,
  parameter int IN_TIMEOUT = 2 * (`LDDPC_CLK_HZ / `LDDPC_IN_MIN_HZ)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire lddpc_pkg::lddpc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dim_ratio_input,
  input wire logic range_select,
  input wire logic dim_freq_select,
  input wire logic enable_in,
  input wire lddpc_pkg::lddpc_sense_t sense_cmp,
  output logic [`LDDPC_NUM_CH-1:0] led_channel_sense_o,
  output logic [`LDDPC_NUM_CH-1:0] led_channel_sense_oe_n,
  output logic [`LDDPC_NUM_CH-1:0] led_drive,
  output logic dimming_ratio_pulse,
  output logic boost_switch_en,
  output logic feedback_ground_switch
);
  import lddpc_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2+2*`LDDPC_NUM_CH:0] pin1_r, pin2_r;
  wire [2+2*`LDDPC_NUM_CH:0] pins = {range_select, dim_freq_select, enable_in, sense_cmp};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_r <= '0;
      pin2_r <= '0;
    end else begin
      pin1_r <= pins;
      pin2_r <= pin1_r;
    end
  end

  wire range_s = pin2_r[2+2*`LDDPC_NUM_CH];
  wire direct_s = pin2_r[1+2*`LDDPC_NUM_CH];
  wire en_s = pin2_r[2*`LDDPC_NUM_CH]; // [R14]
  lddpc_sense_t sense_s;
  assign sense_s = pin2_r[2*`LDDPC_NUM_CH-1:0];

  // ************************************************************
  // duty measurement and averaging
  // ************************************************************
  logic [`LDDPC_DUTY_BITS-1:0] duty_q;
  logic duty_valid;

  lddpc_duty_meter #(
    .CNT_W(PER_W),
    .TIMEOUT(IN_TIMEOUT)
  ) u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .dim_ratio_input(dim_ratio_input),
    .duty_q(duty_q),
    .duty_valid(duty_valid)
  );

  localparam int ACC_W = `LDDPC_DUTY_BITS + `LDDPC_AVG_SHIFT;
  logic [ACC_W-1:0] acc_r;
  wire [ACC_W-1:0] acc_nxt = acc_r - (acc_r >> `LDDPC_AVG_SHIFT) + ACC_W'(duty_q);
  wire [`LDDPC_DUTY_BITS-1:0] avg = acc_r[ACC_W-1:`LDDPC_AVG_SHIFT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (duty_valid) begin
      acc_r <= acc_nxt; // [R9]
    end
  end

  // ************************************************************
  // level selection with hysteresis
  // ************************************************************
  logic [3:0] level_r;
  wire [`LDDPC_DUTY_BITS-1:0] nom = lddpc_nominal(level_r); // [R5]
  wire go_up = (level_r != `LDDPC_LEVEL_MAX) && (avg > nom + `LDDPC_HYST_UNITS); // [R6] [R8]
  wire go_dn = (level_r != `LDDPC_LEVEL_RST) && (avg + `LDDPC_HYST_UNITS < nom); // [R7] [R8]
  wire [3:0] level_nxt = go_up ? level_r + 4'h1 : (go_dn ? level_r - 4'h1 : level_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= `LDDPC_LEVEL_RST;
    end else begin
      level_r <= level_nxt; // [R4]
    end
  end

  // ************************************************************
  // period register, range clamp and dimming pulse
  // ************************************************************
  logic [PER_W-1:0] per_reg_r, per_cur_r, cnt_r, high_cur_r;
  logic pulse_r;
  wire [PER_W-1:0] per_min = range_s ? PER_W'(HF_MIN_PER) : PER_W'(LF_MIN_PER); // [R1] [R2]
  wire [PER_W-1:0] per_max = range_s ? PER_W'(HF_MAX_PER) : PER_W'(LF_MAX_PER); // [R1] [R2]
  wire [PER_W-1:0] per_eff = (per_reg_r < per_min) ? per_min : ((per_reg_r > per_max) ? per_max : per_reg_r);
  wire [PER_W+`LDDPC_DUTY_BITS-1:0] prod = per_eff * lddpc_ratio(level_r);
  wire [PER_W-1:0] high_nxt = prod[PER_W+`LDDPC_FRAC_BITS-1:`LDDPC_FRAC_BITS];
  wire per_end = (cnt_r >= per_cur_r - PER_W'(1));
  wire pulse_nxt = en_s & (direct_s ? range_s : (cnt_r < high_cur_r)); // [R3]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      per_cur_r <= PER_W'(PER_RST);
      high_cur_r <= '0;
    end else if (per_end) begin
      cnt_r <= '0;
      per_cur_r <= per_eff; // [R10]
      high_cur_r <= high_nxt; // [R21]
    end else begin
      cnt_r <= cnt_r + PER_W'(1); // [R21]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  assign dimming_ratio_pulse = pulse_r;
  assign boost_switch_en = pulse_r; // [R16] [R17]
  assign feedback_ground_switch = en_s; // [R15]

  // ************************************************************
  // channel fault latches
  // ************************************************************
  function automatic logic [`LDDPC_NUM_CH-1:0] accept_faults(input logic [`LDDPC_NUM_CH-1:0] cur,
                                                                input logic [`LDDPC_NUM_CH-1:0] req);
    logic [2:0] n;
    n = 3'h0;
    accept_faults = cur;
    for (int i = 0; i < `LDDPC_NUM_CH; i++) begin
      n = n + 3'(cur[i]);
    end
    for (int i = 0; i < `LDDPC_NUM_CH; i++) begin
      if (req[i] && !cur[i] && (n < `LDDPC_FAULT_LIMIT)) begin
        accept_faults[i] = 1'b1;
        n = n + 3'h1;
      end
    end
  endfunction : accept_faults

  logic [`LDDPC_NUM_CH-1:0] fault_r;
  wire [`LDDPC_NUM_CH-1:0] fault_req = led_drive & (sense_s.below_open | sense_s.above_short); // [R11] [R12]
  wire [`LDDPC_NUM_CH-1:0] fault_nxt = accept_faults(fault_r, fault_req); // [R19]
  wire [2:0] fault_cnt = 3'($countones(fault_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_nxt; // [R18]
    end
  end

  assign led_drive = {`LDDPC_NUM_CH{pulse_r}} & ~fault_r; // [R11] [R12]
  assign led_channel_sense_o = '0;
  assign led_channel_sense_oe_n = fault_r; // [R13]

  // ************************************************************
  // apb slave
  // ************************************************************
  wire setup = apb_req.psel & ~apb_req.penable;
  wire acc_ph = apb_req.psel & apb_req.penable;
  wire hit_per = (apb_req.paddr == `LDDPC_REG_PERIOD);
  wire hit_st = (apb_req.paddr == `LDDPC_REG_STATUS);
  wire hit_duty = (apb_req.paddr == `LDDPC_REG_DUTY);
  wire hit_any = hit_per | hit_st | hit_duty;
  wire [31:0] status_w = (32'(level_r) << `LDDPC_ST_LEVEL_LSB) | (32'(fault_r) << `LDDPC_ST_FAULT_LSB)
                       | (32'(direct_s) << `LDDPC_ST_DIRECT_BIT) | (32'(en_s) << `LDDPC_ST_EN_BIT)
                       | (32'(fault_cnt) << `LDDPC_ST_FCNT_LSB);
  wire [31:0] rd_mux = hit_per ? 32'(per_reg_r) : (hit_st ? status_w : (hit_duty ? 32'(avg) : 32'h0));
  wire wr_per = acc_ph & apb_req.pwrite & hit_per;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_reg_r <= PER_W'(PER_RST);
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      if (wr_per) begin
        per_reg_r <= apb_req.pwdata[PER_W-1:0];
      end
      if (setup) begin
        prdata <= apb_req.pwrite ? 32'h0 : rd_mux;
        pslverr <= ~hit_any;
      end
    end
  end

  assign pready = 1'b1;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_lf_period;
    @(posedge pclk) disable iff (!presetn)
      per_end && !range_s |=> (per_cur_r >= PER_W'(LF_MIN_PER)) && (per_cur_r <= PER_W'(LF_MAX_PER));
  endproperty
  a_lf_period: assert property (p_lf_period) else $error("low range period out of bounds"); // [R1]

  property p_hf_period;
    @(posedge pclk) disable iff (!presetn)
      per_end && range_s |=> (per_cur_r >= PER_W'(HF_MIN_PER)) && (per_cur_r <= PER_W'(HF_MAX_PER));
  endproperty
  a_hf_period: assert property (p_hf_period) else $error("high range period out of bounds"); // [R2]

  property p_direct;
    @(posedge pclk) disable iff (!presetn)
      en_s && direct_s ##1 en_s && direct_s |-> dimming_ratio_pulse == $past(range_s);
  endproperty
  a_direct: assert property (p_direct) else $error("direct pulse not passed through"); // [R3]

  property p_level_step;
    @(posedge pclk) disable iff (!presetn)
      $changed(level_r) |-> (level_r == $past(level_r) + 4'h1) || (level_r == $past(level_r) - 4'h1);
  endproperty
  a_level_step: assert property (p_level_step) else $error("level moved by more than one"); // [R4]

  property p_up_thr;
    @(posedge pclk) disable iff (!presetn)
      level_r > $past(level_r) |-> $past(avg) > lddpc_nominal($past(level_r)) + `LDDPC_HYST_UNITS;
  endproperty
  a_up_thr: assert property (p_up_thr) else $error("level rose below threshold"); // [R6]

  property p_dn_thr;
    @(posedge pclk) disable iff (!presetn)
      level_r < $past(level_r) |-> $past(avg) + `LDDPC_HYST_UNITS < lddpc_nominal($past(level_r));
  endproperty
  a_dn_thr: assert property (p_dn_thr) else $error("level fell above threshold"); // [R7]

  property p_fault_off;
    @(posedge pclk) disable iff (!presetn)
      (fault_req != '0) && (fault_cnt == 3'h0) |=> (led_drive & $past(fault_req)) == '0;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("faulted channel still driven"); // [R11]

  property p_fault_hiz;
    @(posedge pclk) disable iff (!presetn)
      $rose(fault_r[0]) |-> led_channel_sense_oe_n[0] && !led_drive[0];
  endproperty
  a_fault_hiz: assert property (p_fault_hiz) else $error("faulted sense pin still driven"); // [R13]

  property p_fault_sticky;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (fault_r & $past(fault_r)) == $past(fault_r);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault latch cleared"); // [R18]

  property p_fault_limit;
    @(posedge pclk) disable iff (!presetn)
      fault_cnt == `LDDPC_FAULT_LIMIT |=> $stable(fault_r);
  endproperty
  a_fault_limit: assert property (p_fault_limit) else $error("fault taken past the limit"); // [R19]

  property p_fb_switch;
    @(posedge pclk) disable iff (!presetn)
      !en_s |-> !feedback_ground_switch ##1 !boost_switch_en;
  endproperty
  a_fb_switch: assert property (p_fb_switch) else $error("disabled but switch or boost active"); // [R15]

  property p_boost_gap;
    @(posedge pclk) disable iff (!presetn)
      en_s && !direct_s && (cnt_r >= high_cur_r) |=> !boost_switch_en;
  endproperty
  a_boost_gap: assert property (p_boost_gap) else $error("boost active in dimming gap"); // [R16]

  property p_boost_on;
    @(posedge pclk) disable iff (!presetn)
      en_s && !direct_s && (cnt_r < high_cur_r) |=> boost_switch_en;
  endproperty
  a_boost_on: assert property (p_boost_on) else $error("boost idle in dimming pulse"); // [R17]

  property p_per_hold;
    @(posedge pclk) disable iff (!presetn)
      !per_end |=> $stable(per_cur_r);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("period changed mid period"); // [R10]

  property p_acc_hold;
    @(posedge pclk) disable iff (!presetn)
      !duty_valid |=> $stable(acc_r);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("average moved without a sample"); // [R9]

  property p_duty_range;
    @(posedge pclk) disable iff (!presetn)
      duty_valid |-> duty_q <= `LDDPC_DUTY_FULL;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty sample above full scale"); // [R20]

  property p_fault_max;
    @(posedge pclk) disable iff (!presetn)
      fault_cnt <= `LDDPC_FAULT_LIMIT;
  endproperty
  a_fault_max: assert property (p_fault_max) else $error("more faults than the limit"); // [R19]

  c_top_level: cover property (@(posedge pclk) disable iff (!presetn) level_r == `LDDPC_LEVEL_MAX);
  c_four_faults: cover property (@(posedge pclk) disable iff (!presetn) fault_cnt == `LDDPC_FAULT_LIMIT);
  c_direct_pulse: cover property (@(posedge pclk) disable iff (!presetn) direct_s && $rose(dimming_ratio_pulse));
  c_level_down: cover property (@(posedge pclk) disable iff (!presetn) go_dn);

endmodule : lddpc_controller

/* File: lddpc_defines.svh */
// constants for the log dimming pwm controller
`ifndef LDDPC_DEFINES_SVH
`define LDDPC_DEFINES_SVH

// ************************************************************
// clock and frequency figures
// ************************************************************
`define LDDPC_CLK_HZ 200000000
`define LDDPC_LF_MIN_HZ 100
`define LDDPC_LF_MAX_HZ 2000
`define LDDPC_HF_MIN_HZ 1500
`define LDDPC_HF_MAX_HZ 20000
`define LDDPC_IN_MIN_HZ 100
`define LDDPC_DIM_DEF_HZ 1000

// ************************************************************
// duty arithmetic, 1024 units are 100 percent
// ************************************************************
`define LDDPC_DUTY_BITS 11
`define LDDPC_FRAC_BITS 10
`define LDDPC_DUTY_FULL 11'h400
`define LDDPC_LEVEL_STEP 11'h040
`define LDDPC_HYST_UNITS 11'h02B
`define LDDPC_AVG_SHIFT 4
`define LDDPC_DIV_STEPS 4'hA
`define LDDPC_LEVEL_MAX 4'hF
`define LDDPC_LEVEL_RST 4'h0

// ************************************************************
// channels and faults
// ************************************************************
`define LDDPC_NUM_CH 6
`define LDDPC_FAULT_LIMIT 3'h4

// ************************************************************
// register map and status fields
// ************************************************************
`define LDDPC_ADDR_W 12
`define LDDPC_REG_PERIOD 12'h000
`define LDDPC_REG_STATUS 12'h004
`define LDDPC_REG_DUTY 12'h008
`define LDDPC_ST_LEVEL_LSB 0
`define LDDPC_ST_FAULT_LSB 4
`define LDDPC_ST_DIRECT_BIT 10
`define LDDPC_ST_EN_BIT 11
`define LDDPC_ST_FCNT_LSB 12

`endif

/* File: lddpc_pkg.sv */
// types and tables for the log dimming pwm controller
`include "lddpc_defines.svh"

package lddpc_pkg;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [`LDDPC_NUM_CH-1:0] below_open;
    logic [`LDDPC_NUM_CH-1:0] above_short;
  } lddpc_sense_t;

  typedef struct packed {
    logic [`LDDPC_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } lddpc_apb_req_t;

  typedef enum logic [0:0] {DV_IDLE, DV_RUN} lddpc_div_state_t;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [`LDDPC_DUTY_BITS-1:0] lddpc_ratio(input logic [3:0] lvl);
    case (lvl)
      4'h0: lddpc_ratio = 11'h000;
      4'h1: lddpc_ratio = 11'h00A;
      4'h2: lddpc_ratio = 11'h00E;
      4'h3: lddpc_ratio = 11'h014;
      4'h4: lddpc_ratio = 11'h01B;
      4'h5: lddpc_ratio = 11'h026;
      4'h6: lddpc_ratio = 11'h035;
      4'h7: lddpc_ratio = 11'h04A;
      4'h8: lddpc_ratio = 11'h066;
      4'h9: lddpc_ratio = 11'h08E;
      4'hA: lddpc_ratio = 11'h0C6;
      4'hB: lddpc_ratio = 11'h113;
      4'hC: lddpc_ratio = 11'h17E;
      4'hD: lddpc_ratio = 11'h212;
      4'hE: lddpc_ratio = 11'h2E1;
      default: lddpc_ratio = `LDDPC_DUTY_FULL;
    endcase
  endfunction : lddpc_ratio

  function automatic logic [`LDDPC_DUTY_BITS-1:0] lddpc_nominal(input logic [3:0] lvl);
    lddpc_nominal = 11'({7'h00, lvl} * `LDDPC_LEVEL_STEP);
  endfunction : lddpc_nominal

endpackage : lddpc_pkg

/* File: lddpc_duty_meter.sv */
// duty cycle meter for the dimming input with serial divider
`timescale 1ns/100ps
`include "lddpc_defines.svh"

module lddpc_duty_meter #(
  parameter int CNT_W = 22,
  parameter int TIMEOUT = 2 * (`LDDPC_CLK_HZ / `LDDPC_IN_MIN_HZ)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dim_ratio_input,
  output logic [`LDDPC_DUTY_BITS-1:0] duty_q,
  output logic duty_valid
);
  import lddpc_pkg::*;

  // ************************************************************
  // input synchroniser and edge detect
  // ************************************************************
  logic s1_r, s2_r, s3_r;
  wire rise = s2_r & ~s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= dim_ratio_input;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ************************************************************
  // high and total counters per input period
  // ************************************************************
  logic [CNT_W-1:0] hi_r, tot_r;
  wire tmo = (tot_r == CNT_W'(TIMEOUT - 1));
  wire start = (rise & (tot_r != '0)) | tmo;
  wire [CNT_W-1:0] hi_ld = tmo ? (s2_r ? tot_r : '0) : hi_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_r <= '0;
      tot_r <= '0;
    end else if (start) begin
      tot_r <= CNT_W'(1);
      hi_r <= CNT_W'(s2_r);
    end else begin
      tot_r <= tot_r + CNT_W'(1);
      hi_r <= hi_r + CNT_W'(s2_r);
    end
  end

  // ************************************************************
  // restoring divider: duty = high * 1024 / total
  // ************************************************************
  lddpc_div_state_t st_r;
  logic [CNT_W:0] rem_r;
  logic [CNT_W-1:0] dvs_r;
  logic [`LDDPC_DUTY_BITS-1:0] quo_r;
  logic [3:0] step_r;
  wire [CNT_W:0] rem2 = {rem_r[CNT_W-1:0], 1'b0};
  wire ge = rem2 >= {1'b0, dvs_r};
  wire hi_full = hi_ld >= tot_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= DV_IDLE;
      rem_r <= '0;
      dvs_r <= '0;
      quo_r <= '0;
      step_r <= '0;
      duty_q <= '0;
      duty_valid <= 1'b0;
    end else begin
      duty_valid <= 1'b0;
      case (st_r)
        DV_IDLE: begin
          if (start) begin // [R20]
            dvs_r <= tot_r;
            rem_r <= hi_full ? '0 : {1'b0, hi_ld};
            quo_r <= hi_full ? `LDDPC_DUTY_BITS'(1) : '0;
            step_r <= '0;
            st_r <= DV_RUN;
          end
        end
        DV_RUN: begin
          rem_r <= ge ? rem2 - {1'b0, dvs_r} : rem2;
          quo_r <= {quo_r[`LDDPC_DUTY_BITS-2:0], ge};
          step_r <= step_r + 4'h1;
          if (step_r == `LDDPC_DIV_STEPS - 4'h1) begin
            duty_q <= {quo_r[`LDDPC_DUTY_BITS-2:0], ge};
            duty_valid <= 1'b1;
            st_r <= DV_IDLE;
          end
        end
        default: st_r <= DV_IDLE;
      endcase
    end
  end

endmodule : lddpc_duty_meter

/* File: lddpc_host_model.sv */
// host and led string model: dimming pulse source and sense comparator levels
`timescale 1ns/100ps

module lddpc_host_model (
  input wire logic pclk,
  input wire logic [7:0] hi_cyc,
  input wire logic [7:0] per_cyc,
  input wire logic [5:0] open_cmd,
  input wire logic [5:0] short_cmd,
  output logic dim_ratio_input,
  output lddpc_pkg::lddpc_sense_t sense_cmp
);
  import lddpc_pkg::*;
  logic [7:0] cnt_r = 8'h00;
  // ************************************************************
  // dimming pulse at a rate of the host's own choosing
  // ************************************************************
  always @(posedge pclk) begin
    cnt_r <= (cnt_r + 8'h01 >= per_cyc) ? 8'h00 : cnt_r + 8'h01;
  end
  assign dim_ratio_input = cnt_r < hi_cyc;
  // ************************************************************
  // string comparators: open pulls low, shorted leds push high
  // ************************************************************
  assign sense_cmp = '{below_open: open_cmd, above_short: short_cmd};
endmodule : lddpc_host_model

/* File: tb.sv */
// self-checking bench for the log dimming pwm controller
`timescale 1ns/100ps
`include "lddpc_defines.svh"

module tb;
  import lddpc_pkg::*;
  typedef struct {logic [7:0] hi; logic [3:0] lvl; logic rng; logic [31:0] per; int ep;} lddpc_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  lddpc_apb_req_t apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, dim_ratio_input, dimming_ratio_pulse, boost_switch_en, feedback_ground_switch;
  logic range_select = 1'b0;
  logic dim_freq_select = 1'b0;
  logic enable_in = 1'b0; // always driven
  lddpc_sense_t sense_cmp;
  logic [5:0] sense_o, sense_oe_n, led_drive;
  logic [5:0] open_cmd = 6'h00;
  logic [5:0] short_cmd = 6'h00;
  logic [5:0] exp_fault = 6'h00;
  logic [7:0] hi_cyc = 8'h40;
  logic [7:0] per_cyc = 8'h80;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int checks = 0;
  int ratio[16] = '{0, 10, 14, 20, 27, 38, 53, 74, 102, 142, 198, 275, 382, 530, 737, 1024};
  // input high of 128 (halved at 64 in high range), level, range, period written, clamped period
  lddpc_row_t rows[7] = '{'{8'h40, 4'h8, 1'b0, 32'h32, 'h64}, '{8'h70, 4'hE, 1'b1, 32'h1388, 'h85},
    '{8'h08, 4'h1, 1'b0, 32'hBB8, 'h7D0}, '{8'h0D, 4'h1, 1'b0, 32'h5DC, 'h5DC},
    '{8'h0E, 4'h2, 1'b1, 32'h78, 'h78}, '{8'h0B, 4'h2, 1'b0, 32'h7D0, 'h7D0},
    '{8'h0A, 4'h1, 1'b0, 32'h3E8, 'h3E8}};

  always #2.5 pclk = ~pclk;

  lddpc_controller #(.LF_MIN_PER(100), .LF_MAX_PER(2000), .HF_MIN_PER(10), .HF_MAX_PER(133),
    .PER_RST(1000)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dim_ratio_input(dim_ratio_input),
    .range_select(range_select), .dim_freq_select(dim_freq_select), .enable_in(enable_in),
    .sense_cmp(sense_cmp), .led_channel_sense_o(sense_o), .led_channel_sense_oe_n(sense_oe_n),
    .led_drive(led_drive), .dimming_ratio_pulse(dimming_ratio_pulse), .boost_switch_en(boost_switch_en),
    .feedback_ground_switch(feedback_ground_switch));

  lddpc_host_model i_host (.pclk(pclk), .hi_cyc(hi_cyc), .per_cyc(per_cyc), .open_cmd(open_cmd),
    .short_cmd(short_cmd), .dim_ratio_input(dim_ratio_input), .sense_cmp(sense_cmp));

  // ************************************************************
  // report and compare
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic fail_wait();
    n_mismatch++;
    $display("ERROR %0t: wait bound used up", $time);
    final_report();
  endtask : fail_wait

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ************************************************************
  // bus cycle, settling and pulse measurement
  // ************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 20) fail_wait();
    end
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic settle(input logic [31:0] d);
    for (int i = 0; i < 600; i++) begin
      apb(1'b0, `LDDPC_REG_DUTY, 32'h0);
      if (rd === d) return;
      repeat (64) @(posedge pclk);
    end
    fail_wait();
  endtask : settle

  task automatic wait_rise();
    logic last;
    last = 1'b1;
    for (int i = 0; i < 6000; i++) begin
      @(negedge pclk);
      if (!last && dimming_ratio_pulse) return;
      last = dimming_ratio_pulse;
    end
    fail_wait();
  endtask : wait_rise

  task automatic measure(input int ep, input int eh);
    int h;
    logic last;
    h = 0;
    wait_rise();
    for (int i = 0; i < ep; i++) begin
      h += dimming_ratio_pulse;
      chk(boost_switch_en, dimming_ratio_pulse);
      chk(led_drive, {6{dimming_ratio_pulse}} & ~exp_fault);
      last = dimming_ratio_pulse;
      @(negedge pclk);
    end
    chk(32'(h), 32'(eh));
    chk(dimming_ratio_pulse & ~last, 1'b1);
  endtask : measure

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LDDPC_REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(feedback_ground_switch, 1'b0);
    apb(1'b1, `LDDPC_REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `LDDPC_REG_PERIOD, 32'h0);
    chk(rd, 32'h3E8);
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd}, 33'h100000000);
    enable_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(feedback_ground_switch, 1'b1);
    $display("reset and register test done");
    foreach (rows[i]) begin
      @(posedge pclk);
      per_cyc <= rows[i].rng ? 8'h40 : 8'h80;
      hi_cyc <= rows[i].rng ? rows[i].hi >> 1 : rows[i].hi;
      range_select <= rows[i].rng;
      apb(1'b1, `LDDPC_REG_PERIOD, rows[i].per);
      settle(32'(rows[i].hi) << 3);
      apb(1'b0, `LDDPC_REG_STATUS, 32'h0);
      chk(rd[11:0], {1'b1, 7'h00, rows[i].lvl});
      wait_rise();
      measure(rows[i].ep, (rows[i].ep * ratio[rows[i].lvl]) >> 10);
      $display("row %0d done", i);
    end
    @(posedge pclk);
    dim_freq_select <= 1'b1;
    range_select <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(dimming_ratio_pulse, 1'b1);
    apb(1'b0, `LDDPC_REG_STATUS, 32'h0);
    chk(rd[10], 1'b1);
    open_cmd <= 6'h02;
    repeat (10) @(posedge pclk);
    open_cmd <= 6'h00;
    exp_fault = 6'h02;
    repeat (10) @(posedge pclk);
    chk({sense_oe_n, led_drive}, {exp_fault, ~exp_fault});
    short_cmd <= 6'h0D;
    repeat (10) @(posedge pclk);
    open_cmd <= 6'h30;
    exp_fault = 6'h0F;
    repeat (10) @(posedge pclk);
    chk({sense_oe_n, led_drive, sense_o}, {exp_fault, ~exp_fault, 6'h00});
    apb(1'b0, `LDDPC_REG_STATUS, 32'h0);
    chk(rd[14:4], {3'h4, 2'h3, exp_fault});
    range_select <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({dimming_ratio_pulse, led_drive}, 7'h00);
    $display("direct mode and fault test done");
    enable_in <= 1'b0;
    range_select <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({feedback_ground_switch, led_drive}, 7'h00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(sense_oe_n, 6'h00);
    $display("disable test done");
    final_report();
  end
endmodule : tb
